/* File: hdl/fam_defs.svh */
/*
 Constants of the flash address space map: widths, field positions,
 command code, discoverable-parameter layout and lock reset value.
 Assumes it is included by bare name and shared by package and logic.
*/
`ifndef FAM_DEFS_SVH
`define FAM_DEFS_SVH

// ==========================================================
// Address layout
`define FAM_ADDR_W 24
`define FAM_SECT_LSB 12
`define FAM_SECT_W 12
`define FAM_OFS_W 12
`define FAM_MAX_SECTORS 4096
`define FAM_SECTORS_DEF 512

// ==========================================================
// Security registers
`define FAM_SR_COUNT 4
`define FAM_SR_IDX_W 2
`define FAM_SR_SEL_MSB 15
`define FAM_SR_SEL_LSB 12
`define FAM_SR_OFS_W 8
`define FAM_LOCK_RST 4'h1

// ==========================================================
// Discoverable-parameter space
`define FAM_OP_READ_DISC 8'h5A
`define FAM_DISC_TBL_START 8'h80
`define FAM_DISC_TBL_END 8'hBF
`define FAM_DISC_UID_START 8'hF8
`define FAM_BASIC_START_DEF 8'h90
`define FAM_MAP_START_DEF 8'hB0

`endif

/* File: hdl/fam_pkg.sv */
/*
 Types of the flash address space map: command kinds, spaces,
 discoverable-parameter regions and the request and answer carriers.
 Assumes fam_defs.svh is on the include path.
*/
`include "fam_defs.svh"

package fam_pkg;

   // ==========================================================
   // Enumerations
   typedef enum logic [2:0] {
      CMD_ARRAY_READ,
      CMD_ARRAY_PROG,
      CMD_ARRAY_ERASE,
      CMD_SR_READ,
      CMD_SR_PROG,
      CMD_SR_ERASE,
      CMD_SR_LOCK,
      CMD_DISC_READ
   } fam_cmd_t;

   typedef enum logic [1:0] {
      SPACE_NONE,
      SPACE_ARRAY,
      SPACE_SECREG,
      SPACE_DISC
   } fam_space_t;

   typedef enum logic [2:0] {
      DISC_NA,
      DISC_HEADER,
      DISC_VENDOR,
      DISC_BASIC,
      DISC_SECTOR_MAP,
      DISC_RESERVED,
      DISC_UNIQUE_ID
   } fam_disc_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      fam_cmd_t kind;
      logic [7:0] opcode;
      logic [`FAM_ADDR_W-1:0] addr;
   } fam_req_t;

   typedef struct packed {
      fam_space_t space;
      logic [`FAM_SECT_W-1:0] sector;
      logic [`FAM_OFS_W-1:0] offset;
      logic [`FAM_SR_IDX_W-1:0] sr_index;
      fam_disc_t region;
      logic is_write;
      logic granted;
      logic undefined;
   } fam_rsp_t;

endpackage : fam_pkg

/* File: hdl/fam_space_map.sv */
/*
 Address decoder of a serial NOR flash: main array of uniform sectors,
 four one-time-lockable security registers and the read-only
 discoverable-parameter space. One request per cycle, answered one
 cycle later. Assumes the command front end has already collected the
 opcode and the full address, and that requests are synchronous.
*/
// Overview of operation
// - Every space uses full 24-bit address
// - Main array uses uniform 4-kbyte sectors only
// - Low twelve bits offset, upper bits pick sector
// - Four 256-byte security registers, separate space
// - Programmed lock bit makes register unmodifiable
// - Register 0 holds protected discoverable parameters
// - Registers 1-3 erase, program, lock independently
// - Registers decode at 000000h, 001000h, 002000h, 003000h
// - Code 5Ah reads the separate parameter space
// - Parameter space opens with header and pointers
// - Order: header, vendor, basic, sector map
// - Parameter space is read-only to host
// - Header at zero, first table at 0080h
`timescale 1ns/1ps
`include "fam_defs.svh"

module fam_space_map #(
   parameter int SECTOR_COUNT = `FAM_SECTORS_DEF,
   parameter logic [7:0] BASIC_TBL_START = `FAM_BASIC_START_DEF,
   parameter logic [7:0] MAP_TBL_START = `FAM_MAP_START_DEF
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire fam_pkg::fam_req_t req_in,
   output logic rsp_valid_out,
   output fam_pkg::fam_rsp_t rsp_out,
   output logic [`FAM_SR_COUNT-1:0] lock_state_out
);
   import fam_pkg::*;

   // ==========================================================
   // Elaboration checks
   if (SECTOR_COUNT < 1 || SECTOR_COUNT > `FAM_MAX_SECTORS ||
       (SECTOR_COUNT & (SECTOR_COUNT - 1)) != 0) begin : g_bad_sector_count
      $error("SECTOR_COUNT must be a power of two up to 4096");
   end
   if (!(BASIC_TBL_START > `FAM_DISC_TBL_START &&
         MAP_TBL_START > BASIC_TBL_START &&
         MAP_TBL_START <= `FAM_DISC_TBL_END)) begin : g_bad_table_order
      $error("Parameter table starts out of order");
   end

   // Sector mask: upper address bits beyond the array wrap, as a
   // power-of-two array would do with unused address lines.
   localparam logic [`FAM_SECT_W-1:0] SECT_MASK = `FAM_SECT_W'(SECTOR_COUNT - 1);

   // ==========================================================
   // State
   logic rsp_valid_r;
   logic rsp_valid_nxt;
   fam_rsp_t rsp_r;
   fam_rsp_t rsp_nxt;
   logic [`FAM_SR_COUNT-1:0] lock_r;
   logic [`FAM_SR_COUNT-1:0] lock_nxt;

   // ==========================================================
   // Decode
   always_comb begin
      logic is_disc;
      logic sr_hit;
      logic [3:0] sr_sel;
      logic [`FAM_SR_IDX_W-1:0] idx;
      logic [7:0] dofs;
      is_disc = 1'b0;
      sr_hit = 1'b0;
      sr_sel = '0;
      idx = '0;
      dofs = '0;
      rsp_nxt = rsp_r;
      lock_nxt = lock_r;
      rsp_valid_nxt = req_valid_in;
      if (req_valid_in) begin
         rsp_nxt = '0;
         // The dedicated opcode wins over whatever kind came with it.
         is_disc = (req_in.opcode == `FAM_OP_READ_DISC) ||
                   (req_in.kind == CMD_DISC_READ);
         sr_sel = req_in.addr[`FAM_SR_SEL_MSB:`FAM_SR_SEL_LSB];
         idx = sr_sel[`FAM_SR_IDX_W-1:0];
         dofs = req_in.addr[`FAM_SR_OFS_W-1:0];
         // Only the four listed 256-byte windows exist.
         sr_hit = (req_in.addr[`FAM_ADDR_W-1:`FAM_SR_SEL_MSB+1] == '0) &&
                  (req_in.addr[`FAM_SR_SEL_LSB-1:`FAM_SR_OFS_W] == '0) &&
                  (sr_sel < 4'(`FAM_SR_COUNT));
         if (is_disc) begin
            // Separate space, never the array; reads only.
            rsp_nxt.space = SPACE_DISC;
            rsp_nxt.offset = `FAM_OFS_W'(dofs);
            rsp_nxt.undefined =
               (req_in.addr[`FAM_ADDR_W-1:`FAM_SR_OFS_W] != '0);
            rsp_nxt.granted = !rsp_nxt.undefined;
            // Header first at zero, then tables in fixed order.
            if (dofs < `FAM_DISC_TBL_START) begin
               rsp_nxt.region = DISC_HEADER;
            end else if (dofs < BASIC_TBL_START) begin
               rsp_nxt.region = DISC_VENDOR;
            end else if (dofs < MAP_TBL_START) begin
               rsp_nxt.region = DISC_BASIC;
            end else if (dofs <= `FAM_DISC_TBL_END) begin
               rsp_nxt.region = DISC_SECTOR_MAP;
            end else if (dofs < `FAM_DISC_UID_START) begin
               rsp_nxt.region = DISC_RESERVED;
            end else begin
               rsp_nxt.region = DISC_UNIQUE_ID;
            end
         end else if (req_in.kind == CMD_ARRAY_READ ||
                      req_in.kind == CMD_ARRAY_PROG ||
                      req_in.kind == CMD_ARRAY_ERASE) begin
            // Uniform sectors: offset is the low twelve bits.
            rsp_nxt.space = SPACE_ARRAY;
            rsp_nxt.sector = req_in.addr[`FAM_ADDR_W-1:`FAM_SECT_LSB] & SECT_MASK;
            rsp_nxt.offset = req_in.addr[`FAM_OFS_W-1:0];
            rsp_nxt.is_write = (req_in.kind != CMD_ARRAY_READ);
            rsp_nxt.granted = 1'b1;
         end else begin
            // Security register commands.
            rsp_nxt.is_write = (req_in.kind != CMD_SR_READ);
            if (sr_hit) begin
               rsp_nxt.space = SPACE_SECREG;
               rsp_nxt.sr_index = idx;
               rsp_nxt.offset = `FAM_OFS_W'(dofs);
               if (idx == '0) begin
                  rsp_nxt.region = DISC_HEADER;
                  if (dofs >= `FAM_DISC_TBL_START) begin
                     rsp_nxt.region = DISC_VENDOR;
                  end
               end
               // A set lock bit refuses every change, per register.
               rsp_nxt.granted = !(rsp_nxt.is_write && lock_r[idx]);
               if (req_in.kind == CMD_SR_LOCK && !lock_r[idx]) begin
                  lock_nxt[idx] = 1'b1;
               end
            end else begin
               rsp_nxt.space = SPACE_NONE;
               rsp_nxt.undefined = 1'b1;
               rsp_nxt.granted = 1'b0;
            end
         end
      end
      // Register 0 carries factory data and can never be unlocked.
      lock_nxt[0] = 1'b1;
   end

   // ==========================================================
   // Registers
   // Lock bits are flops: a reset reloads them from their reset value, so the
   // lasting copy must be restored by whoever owns the nonvolatile status bits.
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
         lock_r <= `FAM_LOCK_RST;
      end else begin
         rsp_valid_r <= rsp_valid_nxt;
         rsp_r <= rsp_nxt;
         lock_r <= lock_nxt;
      end
   end

   assign rsp_valid_out = rsp_valid_r;
   assign rsp_out = rsp_r;
   assign lock_state_out = lock_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // Field positions in the checks are written out as numbers on purpose, so
   // that a slip in a macro cannot hide behind the same macro in its check.
   logic req_is_disc;
   assign req_is_disc = req_valid_in && (req_in.opcode == `FAM_OP_READ_DISC);

   chk_array_offset: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_ARRAY_READ |=>
      rsp_valid_out && rsp_out.space == SPACE_ARRAY &&
      rsp_out.offset == $past(req_in.addr[11:0]))
      else $error("Array offset not the low twelve address bits");

   chk_sector_index: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_ARRAY_ERASE |=>
      rsp_out.sector == ($past(req_in.addr[23:12]) & SECT_MASK) && rsp_out.is_write)
      else $error("Sector index does not follow upper address bits");

   chk_sr_select: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_SR_READ &&
      req_in.addr[23:16] == 8'h00 && req_in.addr[11:8] == 4'h0 &&
      req_in.addr[15:12] < 4'h4 |=>
      rsp_out.space == SPACE_SECREG && rsp_out.sr_index == $past(req_in.addr[13:12]) &&
      rsp_out.offset == {4'h0, $past(req_in.addr[7:0])})
      else $error("Security register window decoded wrongly");

   chk_sr_undefined: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_SR_READ &&
      req_in.addr[11:8] != 4'h0 |=>
      rsp_out.undefined && !rsp_out.granted && rsp_out.space == SPACE_NONE)
      else $error("Address outside security windows not flagged");

   chk_locked_refused: assert property (
      rsp_valid_out && rsp_out.space == SPACE_SECREG && rsp_out.is_write &&
      $past(lock_r[req_in.addr[13:12]]) |-> !rsp_out.granted)
      else $error("Write to locked security register granted");

   chk_lock_sticky: assert property (
      lock_state_out[2] |=> lock_state_out[2] [*3])
      else $error("Security lock bit cleared");

   chk_lock_indep: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_SR_LOCK &&
      rsp_nxt.space == SPACE_SECREG && rsp_nxt.sr_index == 2'h1 |=>
      lock_state_out[3:2] == $past(lock_state_out[3:2]) && lock_state_out[1])
      else $error("Locking register 1 disturbed another register");

   chk_sfdp_locked: assert property (
      lock_state_out[0] == 1'b1)
      else $error("Parameter register not protected");

   chk_disc_space: assert property (
      req_is_disc && req_in.addr[23:8] == 16'h0000 |=>
      rsp_out.space == SPACE_DISC && !rsp_out.is_write && rsp_out.granted)
      else $error("Parameter read not taken from its own space");

   chk_disc_layout: assert property (
      req_is_disc |=>
      (rsp_out.region == DISC_HEADER) == (rsp_out.offset[7:0] < 8'h80))
      else $error("Header region does not end at 0080h");

   chk_sfdp_write: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_SR_PROG &&
      req_in.addr[23:8] == 16'h0000 |=> !rsp_out.granted)
      else $error("Write to parameter space granted");

   chk_answer_pulse: assert property (
      req_valid_in |=> rsp_valid_out)
      else $error("Request not answered on the next cycle");

   chk_no_spurious: assert property (
      !req_valid_in |=> !rsp_valid_out)
      else $error("Answer without a request");

   chk_array_granted: assert property (
      req_valid_in && !req_is_disc &&
      req_in.kind inside {CMD_ARRAY_READ, CMD_ARRAY_PROG, CMD_ARRAY_ERASE} |=>
      rsp_out.space == SPACE_ARRAY && rsp_out.granted && !rsp_out.undefined)
      else $error("Array access not granted as a plain sector access");

   chk_disc_read_only: assert property (
      req_valid_in && req_in.kind == CMD_DISC_READ |=>
      rsp_out.space == SPACE_DISC && !rsp_out.is_write)
      else $error("Parameter space answered as writable");

   chk_disc_undefined: assert property (
      req_is_disc && req_in.addr[23:8] != 16'h0000 |=>
      rsp_out.undefined && !rsp_out.granted)
      else $error("Parameter address above its space not flagged");

   chk_sfdp_erase: assert property (
      req_valid_in && !req_is_disc && req_in.kind inside {CMD_SR_ERASE, CMD_SR_LOCK} &&
      req_in.addr[23:8] == 16'h0000 |=> !rsp_out.granted)
      else $error("Change to parameter register granted");

   chk_lock_set: assert property (
      req_valid_in && !req_is_disc && req_in.kind == CMD_SR_LOCK &&
      req_in.addr[23:16] == 8'h00 && req_in.addr[11:8] == 4'h0 &&
      req_in.addr[15:12] < 4'h4 |=>
      lock_state_out[$past(req_in.addr[13:12])])
      else $error("Lock command did not set its lock bit");

   chk_region_vendor: assert property (
      req_is_disc && req_in.addr[7:0] >= 8'h80 && req_in.addr[7:0] < BASIC_TBL_START |=>
      rsp_out.region == DISC_VENDOR)
      else $error("Vendor table not first after the header");

   chk_region_basic: assert property (
      req_is_disc && req_in.addr[7:0] >= BASIC_TBL_START &&
      req_in.addr[7:0] < MAP_TBL_START |=>
      rsp_out.region == DISC_BASIC)
      else $error("Basic table not after the vendor table");

   chk_region_map: assert property (
      req_is_disc && req_in.addr[7:0] >= MAP_TBL_START && req_in.addr[7:0] <= 8'hBF |=>
      rsp_out.region == DISC_SECTOR_MAP)
      else $error("Sector map table not last of the tables");

   // Lock bits have no clear path but reset, so a falling bit outside reset can only mean a decode fault.
   for (genvar gi = 0; gi < `FAM_SR_COUNT; gi++) begin : g_lock_held
      chk_lock_held: assert property (@(posedge clk_sys_in) disable iff (rst_in)
         lock_state_out[gi] |=> lock_state_out[gi])
         else $error("Security lock bit cleared");
   end

   cov_array_write: cover property (
      rsp_valid_out && rsp_out.space == SPACE_ARRAY && rsp_out.is_write);
   cov_lock_then_refuse: cover property (
      rsp_valid_out && rsp_out.space == SPACE_SECREG && rsp_out.sr_index == 2'h3 &&
      rsp_out.granted && rsp_out.is_write ##[1:20]
      rsp_valid_out && rsp_out.sr_index == 2'h3 && !rsp_out.granted);
   cov_disc_uid: cover property (
      rsp_valid_out && rsp_out.region == DISC_UNIQUE_ID);
   cov_undefined: cover property (rsp_valid_out && rsp_out.undefined);
   cov_reg1_lock: cover property (rsp_valid_out && rsp_out.sr_index == 2'h1 && lock_state_out[1]);

endmodule : fam_space_map

/* File: test/fam_host_model.sv */
/*
 Host-side command model for the flash address space map: presents one
 complete request per call and keeps the request bus moving while idle.
 Assumes a single system clock whose rising edge takes each request.
*/
`timescale 1ns/1ps

module fam_host_model (
   input wire logic clk_sys_in,
   output logic req_valid_out,
   output fam_pkg::fam_req_t req_out
);
   import fam_pkg::*;

   // ==========================================================
   // Request driving
   initial begin
      req_valid_out = 1'b0;
      req_out = '0;
   end

   // Every request carries all 24 address bits, even for the small spaces.
   task automatic send(input fam_cmd_t kind, input logic [7:0] op, input logic [23:0] addr);
      req_valid_out <= 1'b1;
      req_out <= '{kind: kind, opcode: op, addr: addr};
      @(posedge clk_sys_in);
   endtask : send

   // A released bus toggles, so a stale address can never pass for a live one.
   task automatic idle(input int n);
      repeat (n) begin
         req_valid_out <= 1'b0;
         req_out <= ~req_out;
         @(posedge clk_sys_in);
      end
   endtask : idle
endmodule : fam_host_model

/* File: test/flash_address_space_map_test.sv */
/*
 Self-checking bench of the flash address space map: table of decodes,
 then reset, lock and back-to-back cases written by hand.
 Assumes fam_defs.svh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
`include "fam_defs.svh"

module flash_address_space_map_test;
   import fam_pkg::*;

   // ==========================================================
   // Signals and instances
   localparam int SECTORS = 512;
   localparam logic [7:0] RD_DISC = `FAM_OP_READ_DISC;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid;
   fam_req_t req;
   logic rsp_valid;
   fam_rsp_t rsp;
   logic [3:0] lock_state;
   int error_cnt = 0;
   int checked = 0;

   typedef struct {
      fam_cmd_t kind; logic [7:0] op; logic [23:0] addr;
      fam_space_t sp; fam_disc_t rg; logic gr; logic un;
   } fam_row_t;

   // SPACE_NONE in a row means the space is not compared (undefined address).
   fam_row_t rows[] = '{
      '{CMD_ARRAY_READ, 8'h03, 24'h000000, SPACE_ARRAY, DISC_NA, 1, 0},
      '{CMD_ARRAY_PROG, 8'h02, 24'h1FFFFF, SPACE_ARRAY, DISC_NA, 1, 0},
      '{CMD_ARRAY_ERASE, 8'h20, 24'h001FFF, SPACE_ARRAY, DISC_NA, 1, 0},
      '{CMD_ARRAY_READ, 8'h03, 24'h200ABC, SPACE_ARRAY, DISC_NA, 1, 0},
      '{CMD_SR_READ, 8'h48, 24'h0000FF, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_READ, 8'h48, 24'h003080, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_READ, 8'h48, 24'h004000, SPACE_NONE, DISC_NA, 0, 1},
      '{CMD_SR_READ, 8'h48, 24'h001100, SPACE_NONE, DISC_NA, 0, 1},
      '{CMD_SR_READ, 8'h48, 24'h010000, SPACE_NONE, DISC_NA, 0, 1},
      '{CMD_SR_PROG, 8'h42, 24'h000010, SPACE_SECREG, DISC_NA, 0, 0},
      '{CMD_SR_ERASE, 8'h44, 24'h000000, SPACE_SECREG, DISC_NA, 0, 0},
      '{CMD_SR_PROG, 8'h42, 24'h0010FF, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_ERASE, 8'h44, 24'h002000, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h000000, SPACE_DISC, DISC_HEADER, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h00007F, SPACE_DISC, DISC_HEADER, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h000080, SPACE_DISC, DISC_VENDOR, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h000090, SPACE_DISC, DISC_BASIC, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h0000B0, SPACE_DISC, DISC_SECTOR_MAP, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h0000BF, SPACE_DISC, DISC_SECTOR_MAP, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h0000C0, SPACE_DISC, DISC_RESERVED, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h0000F8, SPACE_DISC, DISC_UNIQUE_ID, 1, 0},
      '{CMD_DISC_READ, RD_DISC, 24'h000100, SPACE_NONE, DISC_NA, 0, 1},
      '{CMD_ARRAY_PROG, RD_DISC, 24'h000081, SPACE_DISC, DISC_VENDOR, 1, 0}
   };
   fam_row_t hand[] = '{
      '{CMD_SR_PROG, 8'h42, 24'h001020, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_LOCK, 8'h4C, 24'h003000, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_ERASE, 8'h44, 24'h003010, SPACE_SECREG, DISC_NA, 0, 0},
      '{CMD_SR_LOCK, 8'h4C, 24'h000000, SPACE_SECREG, DISC_NA, 0, 0},
      '{CMD_SR_PROG, 8'h42, 24'h0010F0, SPACE_SECREG, DISC_NA, 1, 0},
      '{CMD_SR_LOCK, 8'h4C, 24'h001000, SPACE_SECREG, DISC_NA, 1, 0}
   };

   fam_space_map #(
      .SECTOR_COUNT(SECTORS),
      .BASIC_TBL_START(8'h90),
      .MAP_TBL_START(8'hB0)
   ) dut (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .req_valid_in(req_valid),
      .req_in(req),
      .rsp_valid_out(rsp_valid),
      .rsp_out(rsp),
      .lock_state_out(lock_state)
   );

   fam_host_model host (
      .clk_sys_in(clk_sys_in),
      .req_valid_out(req_valid),
      .req_out(req)
   );

   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ==========================================================
   // Checking tasks
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // Outputs are read in the active region of the edge after the taking edge,
   // before the design's own updates of that edge land.
   task automatic xfer(input fam_row_t r);
      host.send(r.kind, r.op, r.addr);
      chk(rsp_valid, 1'b0, "answer too early or too long");
      host.idle(1);
      chk(rsp_valid, 1'b1, "answer missing");
      chk(rsp.granted, r.gr, "granted");
      chk(rsp.undefined, r.un, "undefined");
      if (r.sp != SPACE_NONE) chk(rsp.space, r.sp, "space");
      if (r.sp == SPACE_ARRAY) begin
         chk(rsp.sector, r.addr[23:12] & 12'(SECTORS - 1), "sector");
         chk(rsp.offset, r.addr[11:0], "array offset");
      end
      if (r.sp == SPACE_SECREG) begin
         chk(rsp.sr_index, r.addr[13:12], "register index");
         chk(rsp.offset, {4'h0, r.addr[7:0]}, "register offset");
      end
      if (r.sp == SPACE_DISC) chk(rsp.region, r.rg, "region");
      chk(rsp.is_write, r.op != RD_DISC && r.kind inside {CMD_ARRAY_PROG, CMD_ARRAY_ERASE,
         CMD_SR_PROG, CMD_SR_ERASE, CMD_SR_LOCK}, "write flag");
   endtask : xfer

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // ==========================================================
   // Tests
   initial begin
      repeat (6) @(posedge clk_sys_in);
      chk(rsp_valid, 1'b0, "answer in reset");
      chk(lock_state, `FAM_LOCK_RST, "lock bits in reset");
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      $display("Test done: reset");
      foreach (rows[i]) xfer(rows[i]);
      $display("Test done: decode table");
      // Back-to-back lock then program of the same register.
      host.send(CMD_SR_LOCK, 8'h4C, 24'h002000);
      host.send(CMD_SR_PROG, 8'h42, 24'h002010);
      chk(rsp.granted, 1'b1, "lock granted");
      chk(rsp.sr_index, 2'd2, "lock index");
      host.idle(1);
      chk(rsp_valid, 1'b1, "second answer");
      chk(rsp.granted, 1'b0, "locked write refused");
      chk(lock_state, `FAM_LOCK_RST | 4'h4, "lock bits");
      $display("Test done: lock then program");
      foreach (hand[i]) xfer(hand[i]);
      chk(lock_state, `FAM_LOCK_RST | 4'hE, "independent lock bits");
      $display("Test done: independent registers");
      // A reset in mid-run must swallow the answer to the request just taken.
      host.send(CMD_ARRAY_READ, 8'h03, 24'h000123);
      rst_in <= 1'b1;
      host.idle(1);
      chk(rsp_valid, 1'b0, "answer cut by second reset");
      chk(lock_state[0], 1'b1, "parameter lock after second reset");
      rst_in <= 1'b0;
      xfer(rows[3]);
      $display("Test done: reset in mid-run");
      end_sim();
   end

   // The whole run is under two hundred cycles; the watchdog allows a thousand.
   initial begin
      #5000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : flash_address_space_map_test
